/* File: include/scc_consts.vh */
// Constants for the SMBus clock configuration register bank.
`ifndef SCC_CONSTS_VH
`define SCC_CONSTS_VH

// Register indices.
`define SCC_IDX_PAIR_EN      8'h00
`define SCC_IDX_SPREAD_AMP   8'h01
`define SCC_IDX_PAIR_EDGE    8'h02
`define SCC_IDX_XTAL_COPY    8'h03
`define SCC_IDX_RSVD_ONES    8'h04
`define SCC_IDX_REV_MAKER    8'h05
`define SCC_IDX_TYPE_ID      8'h06
`define SCC_IDX_READ_LEN     8'h07

// Power-up values of the writable fields.
`define SCC_RST_PAIR_EN      4'hf
`define SCC_RST_SPREAD_OVR   1'h0
`define SCC_RST_SPREAD_SW    2'h0
`define SCC_RST_AMPLITUDE    2'h2
`define SCC_RST_PAIR_EDGE    4'hf
`define SCC_RST_REF_EDGE     2'h1
`define SCC_RST_REF_WAKE     1'h0
`define SCC_RST_REF_EN       1'h1
`define SCC_RST_READ_LEN     5'h08

// Fixed read values.
`define SCC_RSVD_BYTE        8'hff
`define SCC_RSVD_NIBBLE      4'hf
`define SCC_UNMAPPED_BYTE    8'h00

// Field positions.
`define SCC_B1_OVR_BIT       5
`define SCC_B3_WAKE_BIT      5
`define SCC_B3_EN_BIT        4

// Default target addresses for the two strap levels, seven bits.
`define SCC_ADDR_STRAP_LO    7'h68
`define SCC_ADDR_STRAP_HI    7'h6a

// Cycles the strap synchronisers need before the strap is latched.
`define SCC_STRAP_SETTLE     2'h3

`endif

/* File: design/scc_regs.v */
// SMBus target with the clock generator configuration and status register bank.
`timescale 1ns/1ps
`default_nettype none
`include "scc_consts.vh"

// Behaviour
// - Target address comes from latched strap pin.
// - Register 0 bits 3:0 gate pairs, reset ones.
// - Register 1 bits 7:6 show latched spread strap.
// - Register 1 bit 5 picks strap or software spread.
// - Software spread field bits 4:3, reset 00.
// - Amplitude field bits 1:0, reset 10.
// - Register 2 bits 3:0 pick pair edge rate.
// - Register 3 bits 7:6 crystal copy edge, reset 01.
// - Register 3 bit 5 keeps copy running powered down.
// - Register 3 bit 4 enables crystal copy, reset 1.
// - Register 4 always reads all ones.
// - Register 5 holds fixed revision and maker codes.
// - Register 6 holds fixed type and identifier.
// - Register 7 bits 4:0 set read length, eight.
// - Block write: index, count, data, all acknowledged.
// - Block read: count byte then data until host nack.
module scc_regs #(
    parameter [3:0] REVISION_CODE = 4'h3,  // Arbitrary value.
    parameter [3:0] MAKER_CODE    = 4'h9,  // Arbitrary value.
    parameter [1:0] PART_TYPE     = 2'h2,  // Arbitrary value.
    parameter [5:0] PART_IDENT    = 6'h15  // Arbitrary value.
) (
    input  wire       clock,
    input  wire       rst_b,
    input  wire       sclIn,
    input  wire       sdaIn,
    output reg        sdaOut,
    output reg        sdaOe,
    input  wire       addressSelectStrap,
    input  wire [1:0] spreadStrapLevel,
    output reg  [3:0] pairOutputEnable,
    output reg  [3:0] pairEdgeRateSel,
    output reg  [1:0] spreadAmount,
    output reg  [1:0] amplitudeSel,
    output reg  [1:0] refEdgeRateSel,
    output reg        refWakeOnLan,
    output reg        refOutputEnable,
    output reg  [4:0] readLength
);

    localparam [3:0] ST_IDLE     = 4'h0;
    localparam [3:0] ST_ADDR     = 4'h1;
    localparam [3:0] ST_ADDR_ACK = 4'h2;
    localparam [3:0] ST_INDEX    = 4'h3;
    localparam [3:0] ST_IDX_ACK  = 4'h4;
    localparam [3:0] ST_COUNT    = 4'h5;
    localparam [3:0] ST_CNT_ACK  = 4'h6;
    localparam [3:0] ST_WDATA    = 4'h7;
    localparam [3:0] ST_WD_ACK   = 4'h8;
    localparam [3:0] ST_RDATA    = 4'h9;
    localparam [3:0] ST_RACK     = 4'ha;

    // Two-stage synchronisers for every pin; the first stage feeds only the second.
    reg       sclS1_r, sclS2_r, sclQ_r, sdaS1_r, sdaS2_r, sdaQ_r, adrS1_r, adrS2_r;
    reg [1:0] sprS1_r, sprS2_r;

    // Strap latches and protocol state.
    reg       strapDone_r, addrStrap_r, readDir_r, hostNack_r;
    reg [1:0] strapCnt_r, spreadStrap_r;
    reg [3:0] state_r, bitCnt_r;
    reg [7:0] shift_r, txByte_r, index_r, remain_r;

    // Software-visible fields.
    reg       spreadOvr_r, refWake_r, refEn_r;
    reg [1:0] spreadSw_r, amp_r, refEdge_r;
    reg [3:0] pairEn_r, pairEdge_r;
    reg [4:0] readLen_r;

    wire sclRise   = sclS2_r & ~sclQ_r;
    wire sclFall   = ~sclS2_r & sclQ_r;
    wire startSeen = sclS2_r & sclQ_r & sdaQ_r & ~sdaS2_r;
    wire stopSeen  = sclS2_r & sclQ_r & ~sdaQ_r & sdaS2_r;
    wire rxState   = (state_r == ST_ADDR) | (state_r == ST_INDEX) |
                     (state_r == ST_COUNT) | (state_r == ST_WDATA);
    wire [6:0] ownAddr = addrStrap_r ? `SCC_ADDR_STRAP_HI : `SCC_ADDR_STRAP_LO;

    // Read value of one register; reserved bits read as ones except bits 7:5 of register 7, which read zero; unknown indices as zero.
    function [7:0] readByte;
        input [7:0] idx;
        begin
            if (idx == `SCC_IDX_PAIR_EN)
                readByte = {`SCC_RSVD_NIBBLE, pairEn_r};
            else if (idx == `SCC_IDX_SPREAD_AMP)
                readByte = {spreadStrap_r, spreadOvr_r, spreadSw_r, 1'b1, amp_r};
            else if (idx == `SCC_IDX_PAIR_EDGE)
                readByte = {`SCC_RSVD_NIBBLE, pairEdge_r};
            else if (idx == `SCC_IDX_XTAL_COPY)
                readByte = {refEdge_r, refWake_r, refEn_r, `SCC_RSVD_NIBBLE};
            else if (idx == `SCC_IDX_RSVD_ONES)
                readByte = `SCC_RSVD_BYTE;
            else if (idx == `SCC_IDX_REV_MAKER)
                readByte = {REVISION_CODE, MAKER_CODE};
            else if (idx == `SCC_IDX_TYPE_ID)
                readByte = {PART_TYPE, PART_IDENT};
            else if (idx == `SCC_IDX_READ_LEN)
                readByte = {3'h0, readLen_r};
            else
                readByte = `SCC_UNMAPPED_BYTE;
        end
    endfunction

    // Pin synchronisers and edge history.
    always @(posedge clock or negedge rst_b)
    begin
        if (!rst_b)
        begin
            // Bus lines rest high, so no false edge follows reset.
            {sclS1_r, sclS2_r, sclQ_r, sdaS1_r, sdaS2_r, sdaQ_r} <= 6'h3f;
            {adrS1_r, adrS2_r, sprS1_r, sprS2_r}                 <= 6'h00;
        end
        else
        begin
            {sclQ_r, sclS2_r, sclS1_r} <= {sclS2_r, sclS1_r, sclIn};
            {sdaQ_r, sdaS2_r, sdaS1_r} <= {sdaS2_r, sdaS1_r, sdaIn};
            {adrS2_r, adrS1_r}         <= {adrS1_r, addressSelectStrap};
            {sprS2_r, sprS1_r}         <= {sprS1_r, spreadStrapLevel};
        end
    end

    // Straps are caught once, after the synchronisers have settled past reset release,
    // so that a strap pin later reused as an output cannot move the address.
    always @(posedge clock or negedge rst_b)
    begin
        if (!rst_b)
        begin
            strapDone_r   <= 1'b0;
            strapCnt_r    <= 2'h0;
            addrStrap_r   <= 1'b0;
            spreadStrap_r <= 2'h0;
        end
        else if (!strapDone_r)
        begin
            strapCnt_r <= strapCnt_r + 2'h1;
            if (strapCnt_r == `SCC_STRAP_SETTLE)
            begin
                strapDone_r   <= 1'b1;
                addrStrap_r   <= adrS2_r;
                spreadStrap_r <= {sprS2_r[1], sprS2_r[1] | sprS2_r[0]};
            end
        end
    end

    // Outputs that steer the clock generator, all straight from flip-flops.
    always @(posedge clock or negedge rst_b)
    begin
        if (!rst_b)
        begin
            sdaOut           <= 1'b0;
            pairOutputEnable <= `SCC_RST_PAIR_EN;
            pairEdgeRateSel  <= `SCC_RST_PAIR_EDGE;
            spreadAmount     <= 2'h0;
            amplitudeSel     <= `SCC_RST_AMPLITUDE;
            refEdgeRateSel   <= `SCC_RST_REF_EDGE;
            refWakeOnLan     <= `SCC_RST_REF_WAKE;
            refOutputEnable  <= `SCC_RST_REF_EN;
            readLength       <= `SCC_RST_READ_LEN;
        end
        else
        begin
            sdaOut           <= 1'b0;
            pairOutputEnable <= pairEn_r;
            pairEdgeRateSel  <= pairEdge_r;
            spreadAmount     <= spreadOvr_r ? spreadSw_r : spreadStrap_r;
            amplitudeSel     <= amp_r;
            refEdgeRateSel   <= refEdge_r;
            refWakeOnLan     <= refWake_r;
            refOutputEnable  <= refEn_r;
            readLength       <= readLen_r;
        end
    end

    // Byte engine: bits are sampled on a rising SCL edge and the data line is only
    // changed after a falling edge, so the host never sees it move while SCL is high.
    always @(posedge clock or negedge rst_b)
    begin
        if (!rst_b)
        begin
            state_r     <= ST_IDLE;
            bitCnt_r    <= 4'h0;
            shift_r     <= 8'h00;
            txByte_r    <= 8'h00;
            index_r     <= 8'h00;
            remain_r    <= 8'h00;
            readDir_r   <= 1'b0;
            hostNack_r  <= 1'b0;
            sdaOe       <= 1'b0;
            pairEn_r    <= `SCC_RST_PAIR_EN;
            spreadOvr_r <= `SCC_RST_SPREAD_OVR;
            spreadSw_r  <= `SCC_RST_SPREAD_SW;
            amp_r       <= `SCC_RST_AMPLITUDE;
            pairEdge_r  <= `SCC_RST_PAIR_EDGE;
            refEdge_r   <= `SCC_RST_REF_EDGE;
            refWake_r   <= `SCC_RST_REF_WAKE;
            refEn_r     <= `SCC_RST_REF_EN;
            readLen_r   <= `SCC_RST_READ_LEN;
        end
        else if (startSeen)
        begin
            state_r  <= ST_ADDR;
            bitCnt_r <= 4'h0;
            sdaOe    <= 1'b0;
        end
        else if (stopSeen)
        begin
            state_r <= ST_IDLE;
            sdaOe   <= 1'b0;
        end
        else if (sclRise)
        begin
            if (rxState)
            begin
                shift_r  <= {shift_r[6:0], sdaS2_r};
                bitCnt_r <= bitCnt_r + 4'h1;
            end
            else if (state_r == ST_RDATA)
                bitCnt_r <= bitCnt_r + 4'h1;
            else if (state_r == ST_RACK)
                hostNack_r <= sdaS2_r;
        end
        else if (sclFall)
        begin
            case (state_r)
                ST_ADDR, ST_INDEX, ST_COUNT, ST_WDATA:
                begin
                    if (bitCnt_r == 4'h8)
                    begin
                        bitCnt_r <= 4'h0;
                        sdaOe    <= 1'b1;
                        if (state_r == ST_ADDR)
                        begin
                            readDir_r <= shift_r[0];
                            // A foreign address is neither acknowledged nor followed.
                            sdaOe     <= (shift_r[7:1] == ownAddr);
                            state_r   <= (shift_r[7:1] == ownAddr) ? ST_ADDR_ACK : ST_IDLE;
                        end
                        else if (state_r == ST_INDEX)
                        begin
                            index_r <= shift_r;
                            state_r <= ST_IDX_ACK;
                        end
                        else if (state_r == ST_COUNT)
                        begin
                            remain_r <= shift_r;
                            state_r  <= ST_CNT_ACK;
                        end
                        else
                        begin
                            // Bytes beyond the announced count are acknowledged but dropped.
                            state_r <= ST_WD_ACK;
                            if (remain_r != 8'h00)
                            begin
                                remain_r <= remain_r - 8'h01;
                                index_r  <= index_r + 8'h01;
                                // Only writable fields are taken; the rest stay fixed.
                                if (index_r == `SCC_IDX_PAIR_EN)
                                    pairEn_r <= shift_r[3:0];
                                else if (index_r == `SCC_IDX_SPREAD_AMP)
                                begin
                                    spreadOvr_r <= shift_r[`SCC_B1_OVR_BIT];
                                    spreadSw_r  <= shift_r[4:3];
                                    amp_r       <= shift_r[1:0];
                                end
                                else if (index_r == `SCC_IDX_PAIR_EDGE)
                                    pairEdge_r <= shift_r[3:0];
                                else if (index_r == `SCC_IDX_XTAL_COPY)
                                begin
                                    refEdge_r <= shift_r[7:6];
                                    refWake_r <= shift_r[`SCC_B3_WAKE_BIT];
                                    refEn_r   <= shift_r[`SCC_B3_EN_BIT];
                                end
                                else if (index_r == `SCC_IDX_READ_LEN)
                                    readLen_r <= shift_r[4:0];
                            end
                        end
                    end
                end
                ST_ADDR_ACK:
                begin
                    bitCnt_r <= 4'h0;
                    if (readDir_r)
                    begin
                        // The first byte of a block read is the byte count.
                        txByte_r <= {3'h0, readLen_r};
                        sdaOe    <= 1'b1;
                        state_r  <= ST_RDATA;
                    end
                    else
                    begin
                        sdaOe   <= 1'b0;
                        state_r <= ST_INDEX;
                    end
                end
                ST_IDX_ACK, ST_CNT_ACK, ST_WD_ACK:
                begin
                    // Release the acknowledge; the index is followed by the count.
                    sdaOe   <= 1'b0;
                    state_r <= (state_r == ST_IDX_ACK) ? ST_COUNT : ST_WDATA;
                end
                ST_RDATA:
                begin
                    if (bitCnt_r == 4'h8)
                    begin
                        sdaOe   <= 1'b0;
                        state_r <= ST_RACK;
                    end
                    else
                        sdaOe <= ~txByte_r[3'h7 - bitCnt_r[2:0]];
                end
                ST_RACK:
                begin
                    bitCnt_r <= 4'h0;
                    if (hostNack_r)
                        state_r <= ST_IDLE;
                    else
                    begin
                        txByte_r <= readByte(index_r);
                        sdaOe    <= ~|(readByte(index_r) & 8'h80);
                        index_r  <= index_r + 8'h01;
                        state_r  <= ST_RDATA;
                    end
                end
                default:
                    sdaOe <= 1'b0;
            endcase
        end
    end

endmodule // scc_regs

`default_nettype wire

/* File: dv/scc_regs_properties.sv */
// Concurrent checks on the port behaviour of the configuration register bank.
`timescale 1ns/1ps
`default_nettype none
module scc_regs_properties (
    input wire logic       clock,
    input wire logic       rst_b,
    input wire logic       sclIn,
    input wire logic       sdaOut,
    input wire logic       sdaOe,
    input wire logic [1:0] spreadStrapLevel,
    input wire logic [3:0] pairOutputEnable,
    input wire logic [3:0] pairEdgeRateSel,
    input wire logic [1:0] spreadAmount,
    input wire logic [1:0] amplitudeSel,
    input wire logic [1:0] refEdgeRateSel,
    input wire logic       refWakeOnLan,
    input wire logic       refOutputEnable,
    input wire logic [4:0] readLength
);
    logic [2:0]  relCnt;
    logic [18:0] cfgBus;

    default clocking cb @(posedge clock); endclocking
    default disable iff (!rst_b);

    // Counts edges after reset release, saturating, so strap timing can be checked.
    always_ff @(posedge clock or negedge rst_b)
    begin
        if (!rst_b)
            relCnt <= 3'h0;
        else if (relCnt != 3'h7)
            relCnt <= relCnt + 3'h1;
    end

    // Spread is left out because the strap latch also moves it.
    assign cfgBus = {pairOutputEnable, pairEdgeRateSel, amplitudeSel, refEdgeRateSel,
                     refWakeOnLan, refOutputEnable, readLength};

    a_sda_out_low : assert property (sdaOut == 1'b0)
        else $error("Data drive value is not low.");
    a_sda_scl_low : assert property ($changed(sdaOe) |-> !sclIn)
        else $error("Data pull changed while the bus clock was high.");
    a_ack_hold : assert property ($rose(sdaOe) |-> sdaOe [*8])
        else $error("Data pull released too early.");
    a_ack_release : assert property ($rose(sdaOe) |-> ##[8:120] !sdaOe)
        else $error("Data pull held too long.");
    a_reset_defaults : assert property ($rose(rst_b) |-> cfgBus == 19'h7fca8)
        else $error("Configuration outputs left reset with wrong values.");
    a_strap_spread : assert property (relCnt == 3'h5 |->
        spreadAmount == {spreadStrapLevel[1], |spreadStrapLevel})
        else $error("Spread does not follow the latched strap.");
    a_cfg_after_ack : assert property ($changed(cfgBus) |-> $past(sdaOe) && !$past(sdaOe, 2))
        else $error("Configuration changed away from a data acknowledge.");
    a_spread_by_write : assert property (relCnt == 3'h7 && $changed(spreadAmount) |->
        $past(sdaOe) && !$past(sdaOe, 2))
        else $error("Spread changed away from a data acknowledge.");

    c_ack : cover property ($rose(sdaOe));
    c_strap_high : cover property (relCnt == 3'h5 && spreadAmount == 2'h3);
    c_cfg_write : cover property ($changed(cfgBus));
endmodule // scc_regs_properties

bind scc_regs scc_regs_properties i_scc_regs_properties (.clock, .rst_b, .sclIn, .sdaOut, .sdaOe,
    .spreadStrapLevel, .pairOutputEnable, .pairEdgeRateSel, .spreadAmount, .amplitudeSel,
    .refEdgeRateSel, .refWakeOnLan, .refOutputEnable, .readLength);
`default_nettype wire

/* File: dv/scc_host.sv */
// SMBus host model driving the bus clock and data pins of the register bank.
`timescale 1ns/1ps
`default_nettype none
module scc_host #(
    parameter integer HALF = 5
) (
    input  wire logic clock,
    input  wire logic sdaWire,
    output var  logic sclPin,
    output var  logic sdaPin
);
    // Both pins released at start; the bus clock stands high between frames.
    initial
    begin
        sclPin = 1'b1;
        sdaPin = 1'b1;
    end

    task automatic waitc(input integer n);
        repeat (n) @(posedge clock);
    endtask

    // Start or repeated start: data falls while the bus clock is high.
    task automatic start();
        waitc(1);
        sdaPin <= 1'b1;
        waitc(HALF);
        sclPin <= 1'b1;
        waitc(HALF);
        sdaPin <= 1'b0;
        waitc(HALF);
        sclPin <= 1'b0;
    endtask

    // Stop: data rises while the bus clock is high.
    task automatic stop();
        waitc(1);
        sdaPin <= 1'b0;
        waitc(HALF);
        sclPin <= 1'b1;
        waitc(HALF);
        sdaPin <= 1'b1;
        waitc(HALF);
    endtask

    // Data moves only while the clock is low; sampling late in the high phase
    // gives the device's synchronisers time to settle its answer.
    // One bit spans two HALF phases, ten clocks or 50 ns with the default.
    task automatic bitx(input logic b, output logic r);
        waitc(1);
        sdaPin <= b;
        waitc(HALF - 1);
        sclPin <= 1'b1;
        waitc(HALF);
        r = sdaWire;
        sclPin <= 1'b0;
    endtask

    task automatic sendByte(input logic [7:0] d, output logic ack);
        logic   r;
        integer i;
        for (i = 7; i >= 0; i--)
            bitx(d[i], r);
        bitx(1'b1, r);
        ack = ~r;
    endtask

    // Acknowledges every byte but the last, which it refuses before the stop.
    task automatic recvByte(input logic last, output logic [7:0] d);
        logic   r;
        integer i;
        for (i = 0; i < 8; i++)
        begin
            bitx(1'b1, r);
            d = {d[6:0], r};
        end
        bitx(last, r);
    endtask
endmodule // scc_host
`default_nettype wire

/* File: dv/tb_top.sv */
// Self-checking bench for the register bank through SMBus block transfers.
`timescale 1ns/1ps
`default_nettype none
`include "scc_consts.vh"
module tb_top;
    logic        clock, rst_b, sclPin, sdaPin, sdaWire, adrStrap, sdaOut, sdaOe;
    logic        refWakeOnLan, refOutputEnable;
    logic [1:0]  spreadStrap, spreadAmount, amplitudeSel, refEdgeRateSel;
    logic [3:0]  pairOutputEnable, pairEdgeRateSel;
    logic [4:0]  readLength;
    logic [6:0]  devAdr;
    logic [20:0] cfg;
    logic [11:0] spTab [4] = '{12'h222, 12'h72b, 12'h830, 12'h519};
    integer      numErrors = 0;
    integer      checkCount = 0;
    integer      k;

    // Open-drain data line with a pull-up: low when either side pulls.
    assign sdaWire = sdaPin & ~sdaOe;
    assign cfg = {pairOutputEnable, pairEdgeRateSel, spreadAmount, amplitudeSel,
                  refEdgeRateSel, refWakeOnLan, refOutputEnable, readLength};

    scc_regs i_scc_regs (.clock, .rst_b, .sclIn(sclPin), .sdaIn(sdaWire), .sdaOut, .sdaOe,
        .addressSelectStrap(adrStrap), .spreadStrapLevel(spreadStrap), .pairOutputEnable,
        .pairEdgeRateSel, .spreadAmount, .amplitudeSel, .refEdgeRateSel, .refWakeOnLan,
        .refOutputEnable, .readLength);
    scc_host i_scc_host (.clock, .sdaWire, .sclPin, .sdaPin);

    initial
    begin
        clock = 1'b0;
        forever #2.5 clock = ~clock;
    end

    task automatic check(input string nm, input logic [63:0] seen, input logic [63:0] exp);
        checkCount++;
        if (seen !== exp)
        begin
            numErrors++;
            $display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
        end
    endtask

    task automatic printVerdict();
        $display("Checks %0d errors %0d", checkCount, numErrors);
        if (numErrors == 0 && checkCount > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask

    task automatic probe(input logic [6:0] a, input logic exp);
        logic ack;
        i_scc_host.start();
        i_scc_host.sendByte({a, 1'b0}, ack);
        i_scc_host.stop();
        check("addrAck", ack, exp);
    endtask

    task automatic wrBlk(input logic [7:0] idx, input integer n, input logic [63:0] d);
        logic   a, ok;
        integer i;
        i_scc_host.start();
        i_scc_host.sendByte({devAdr, 1'b0}, ok);
        i_scc_host.sendByte(idx, a);
        ok &= a;
        i_scc_host.sendByte(n[7:0], a);
        ok &= a;
        for (i = n - 1; i >= 0; i--)
        begin
            i_scc_host.sendByte(d[8*i +: 8], a);
            ok &= a;
        end
        i_scc_host.stop();
        check("writeAck", ok, 1'b1);
    endtask

    task automatic rdBlk(input logic [7:0] idx, input integer n, input logic [7:0] cnt,
                         input logic [63:0] exp);
        logic        a, ok;
        logic [7:0]  b;
        logic [63:0] got;
        integer      i;
        i_scc_host.start();
        i_scc_host.sendByte({devAdr, 1'b0}, ok);
        i_scc_host.sendByte(idx, a);
        ok &= a;
        i_scc_host.start();
        i_scc_host.sendByte({devAdr, 1'b1}, a);
        check("readAck", ok & a, 1'b1);
        i_scc_host.recvByte(1'b0, b);
        check("countByte", b, cnt);
        got = '0;
        for (i = 0; i < n; i++)
        begin
            i_scc_host.recvByte(i == n - 1, b);
            got = {got[55:0], b};
        end
        i_scc_host.stop();
        check("readData", got, exp);
    endtask

    // A hang is cut short here and counted as a mismatch.
    initial
    begin
        repeat (100000) @(posedge clock);
        numErrors++;
        printVerdict();
    end

    initial
    begin
        rst_b = 1'b0;
        adrStrap = 1'b0;
        spreadStrap = 2'h1;
        devAdr = `SCC_ADDR_STRAP_LO;
        repeat (4) @(posedge clock);
        rst_b <= 1'b1;
        repeat (12) @(posedge clock);
        check("defaults", cfg, {8'hff, 2'h1, 2'h2, 2'h1, 2'h1, 5'h08});
        rdBlk(8'h00, 8, 8'h08, 64'hff46ff5fff399508);
        probe(`SCC_ADDR_STRAP_HI, 1'b0);
        wrBlk(8'h00, 4, 64'h05ff0a20);
        check("written", cfg, {8'h5a, 2'h3, 2'h3, 2'h0, 2'h2, 5'h08});
        rdBlk(8'h00, 4, 8'h08, 64'hf57ffa2f);
        // Software spread codes 00, 01 and 10, the strap fallback and every amplitude.
        for (k = 0; k < 4; k++)
        begin
            wrBlk(8'h01, 1, {56'h0, spTab[k][7:0]});
            check("spreadAmp", {spreadAmount, amplitudeSel}, spTab[k][11:8]);
        end
        wrBlk(8'h07, 1, 64'h03);
        rdBlk(8'h06, 3, 8'h03, 64'h950300);
        wrBlk(8'h04, 3, 64'h0);
        rdBlk(8'h04, 3, 8'h03, 64'hff3995);
        // Second reset with the other strap levels.
        rst_b <= 1'b0;
        adrStrap <= 1'b1;
        spreadStrap <= 2'h2;
        repeat (4) @(posedge clock);
        rst_b <= 1'b1;
        repeat (12) @(posedge clock);
        devAdr = `SCC_ADDR_STRAP_HI;
        check("defaults2", cfg, {8'hff, 2'h3, 2'h2, 2'h1, 2'h1, 5'h08});
        probe(`SCC_ADDR_STRAP_LO, 1'b0);
        rdBlk(8'h01, 1, 8'h08, 64'hc6);
        printVerdict();
    end
endmodule // tb_top
`default_nettype wire
